/* hw/spft_fifo_ctrl.sv */
// Purpose: Fill counting, thresholds, flush and interrupts for serial FIFOs.
// Assumes: All inputs synchronous to ref_clk_i; one clock domain.
// Notes: The FIFO storage lives elsewhere and follows the flush pulses.
//
// The strobed register port is this design's own decision.
module spft_fifo_ctrl (
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic [7:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [31:0] rdata_o,
   input wire logic tx_push_i,
   input wire logic tx_pop_i,
   input wire logic rx_push_i,
   input wire logic rx_pop_i,
   input wire logic master_mode_i,
   input wire logic sclk_tick_i,
   output logic [3:0] tx_count_o,
   output logic [3:0] rx_count_o,
   output logic tx_full_o,
   output logic tx_empty_o,
   output logic rx_full_o,
   output logic rx_empty_o,
   output logic tx_level_flag_o,
   output logic rx_level_flag_o,
   output logic tx_flush_o,
   output logic rx_flush_o,
   output logic irq_o
);

   spft_pkg::spft_ctrl_t ctrl_q;
   spft_pkg::spft_to_state_t to_state_q;
   spft_pkg::spft_to_state_t to_state_d;
   logic [3:0] tx_cnt_q;
   logic [3:0] tx_cnt_d;
   logic [3:0] rx_cnt_q;
   logic [3:0] rx_cnt_d;
   logic tx_full_q;
   logic tx_empty_q;
   logic rx_full_q;
   logic rx_empty_q;
   logic tx_level_q;
   logic rx_level_q;
   logic overrun_q;
   logic timeout_q;
   logic [9:0] to_cnt_q;
   logic [9:0] to_cnt_d;
   logic to_evt;
   logic [3:0] irq_sts_q;
   logic [3:0] irq_mask_q;
   logic [3:0] irq_set;
   logic irq_q;
   logic [31:0] rdata_q;
   logic wr_ctl;
   logic wr_sts;
   logic wr_isr;
   logic wr_imr;
   logic rx_drop;
   logic [31:0] sts_word;

   // Next fill count; a flush wins over any push or pop in the same cycle.
   // A push into a full FIFO and a pop from an empty one are ignored here;
   // the receive side flags its lost word as an overrun elsewhere.
   function automatic logic [3:0] fifo_next(
      input logic [3:0] cnt,
      input logic push,
      input logic pop,
      input logic flush
   );
      logic up;
      logic dn;
      logic [3:0] n;
      // A pop in the same cycle frees the slot that a push into a full FIFO takes.
      up = push && ((cnt != spft_pkg::FIFO_DEPTH) || pop);
      dn = pop && (cnt != 4'h0);
      n = cnt;
      if (flush) begin
         n = 4'h0;
      end else if (up && !dn) begin
         n = cnt + 4'h1;
      end else if (dn && !up) begin
         n = cnt - 4'h1;
      end
      return n;
   endfunction : fifo_next

   function automatic logic is_full(input logic [3:0] cnt);
      return cnt == spft_pkg::FIFO_DEPTH;
   endfunction : is_full

   function automatic logic is_empty(input logic [3:0] cnt);
      return cnt == 4'h0;
   endfunction : is_empty

   // Exact decode: an address that maps to no register touches nothing.
   function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] ofs);
      return addr == ofs;
   endfunction : reg_hit

   // Idle limit for the time-out; the master base only advances on ticks.
   function automatic logic [9:0] to_limit(input logic master);
      logic [9:0] lim;
      lim = spft_pkg::TO_SLAVE_CYCLES;
      if (master) begin
         lim = spft_pkg::TO_MASTER_TICKS;
      end
      return lim;
   endfunction : to_limit

   assign wr_ctl = wr_i && reg_hit(addr_i, spft_pkg::OFS_FIFO_CTL);
   assign wr_sts = wr_i && reg_hit(addr_i, spft_pkg::OFS_FIFO_STS);
   assign wr_isr = wr_i && reg_hit(addr_i, spft_pkg::OFS_IRQ_STS);
   assign wr_imr = wr_i && reg_hit(addr_i, spft_pkg::OFS_IRQ_MASK);

   // Control register; flush bits read as one for a single cycle only.
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ctrl_q <= spft_pkg::CTRL_RESET;
      end else if (wr_ctl) begin
         ctrl_q <= wdata_i & spft_pkg::CTRL_WMASK;
      end else begin
         ctrl_q.tx_flush <= 1'b0;
         ctrl_q.rx_flush <= 1'b0;
      end
   end

   assign tx_cnt_d = fifo_next(tx_cnt_q, tx_push_i, tx_pop_i, ctrl_q.tx_flush);
   assign rx_cnt_d = fifo_next(rx_cnt_q, rx_push_i, rx_pop_i, ctrl_q.rx_flush);

   // Fill counts and the flags derived from them are all registered.
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tx_cnt_q <= 4'h0;
         rx_cnt_q <= 4'h0;
         tx_full_q <= 1'b0;
         rx_full_q <= 1'b0;
         tx_empty_q <= 1'b1;
         rx_empty_q <= 1'b1;
      end else begin
         tx_cnt_q <= tx_cnt_d;
         rx_cnt_q <= rx_cnt_d;
         tx_full_q <= is_full(tx_cnt_d);
         rx_full_q <= is_full(rx_cnt_d);
         tx_empty_q <= is_empty(tx_cnt_d);
         rx_empty_q <= is_empty(rx_cnt_d);
      end
   end

   // Level flags follow the new count against the present thresholds.
   // Registering them costs one cycle of lag after a threshold write, but keeps
   // every output of the block straight from a flop.
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tx_level_q <= 1'b1;
         rx_level_q <= 1'b0;
      end else begin
         tx_level_q <= (tx_cnt_d <= {1'b0, ctrl_q.tx_thr});
         rx_level_q <= (rx_cnt_d > {1'b0, ctrl_q.rx_thr});
      end
   end

   // A word offered to a full receive FIFO is dropped, not stored.
   // A pop in the same cycle makes room; a flush discards everything anyway.
   assign rx_drop = rx_push_i && is_full(rx_cnt_q) && !rx_pop_i && !ctrl_q.rx_flush;

   // Overrun and time-out flags; a new event wins over a clear.
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         overrun_q <= 1'b0;
      end else if (rx_drop) begin
         overrun_q <= 1'b1;
      end else if (wr_sts && wdata_i[spft_pkg::STS_OVERRUN]) begin
         overrun_q <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         timeout_q <= 1'b0;
      end else if (to_evt) begin
         timeout_q <= 1'b1;
      end else if (rx_pop_i || (wr_sts && wdata_i[spft_pkg::STS_TIMEOUT])) begin
         timeout_q <= 1'b0;
      end
   end

   // Time-out watch: runs while the receive FIFO holds data and nobody
   // reads it. In master mode it counts serial clock ticks, in slave mode
   // ref clock cycles. It fires once and waits for a read or an empty FIFO.
   // Clearing the flag by a write does not rearm the watch, so one idle spell
   // raises one event however often software clears it.
   always_comb begin
      to_state_d = to_state_q;
      to_cnt_d = to_cnt_q;
      to_evt = 1'b0;
      case (to_state_q)
         spft_pkg::SPFT_TO_IDLE: begin
            to_cnt_d = 10'h000;
            if (!is_empty(rx_cnt_q) && !rx_pop_i && !ctrl_q.rx_flush) begin
               to_state_d = spft_pkg::SPFT_TO_RUN;
            end
         end
         spft_pkg::SPFT_TO_RUN: begin
            if (rx_pop_i || ctrl_q.rx_flush || is_empty(rx_cnt_q)) begin
               to_state_d = spft_pkg::SPFT_TO_IDLE;
            end else if (master_mode_i ? sclk_tick_i : 1'b1) begin
               to_cnt_d = to_cnt_q + 10'h001;
               if (to_cnt_d >= to_limit(master_mode_i)) begin
                  to_evt = 1'b1;
                  to_state_d = spft_pkg::SPFT_TO_DONE;
               end
            end
         end
         spft_pkg::SPFT_TO_DONE: begin
            if (rx_pop_i || ctrl_q.rx_flush || is_empty(rx_cnt_q)) begin
               to_state_d = spft_pkg::SPFT_TO_IDLE;
            end
         end
         default: begin
            to_state_d = spft_pkg::SPFT_TO_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         to_state_q <= spft_pkg::SPFT_TO_IDLE;
         to_cnt_q <= 10'h000;
      end else begin
         to_state_q <= to_state_d;
         to_cnt_q <= to_cnt_d;
      end
   end

   // Sticky interrupt causes, each gated by its control enable.
   always_comb begin
      irq_set = 4'h0;
      irq_set[spft_pkg::IRQ_RX_LEVEL] = rx_level_q && ctrl_q.rx_level_irq_enable;
      irq_set[spft_pkg::IRQ_TX_LEVEL] = tx_level_q && ctrl_q.tx_level_irq_enable;
      irq_set[spft_pkg::IRQ_OVERRUN] = overrun_q && ctrl_q.rx_overflow_irq_enable;
      irq_set[spft_pkg::IRQ_TIMEOUT] = timeout_q && ctrl_q.rx_idle_irq_enable;
   end

   // Level causes set their bit again every cycle they hold, so software must
   // drop the enable or the level before a clear sticks.
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         irq_sts_q <= 4'h0;
      end else if (wr_isr) begin
         irq_sts_q <= (irq_sts_q & ~wdata_i[3:0]) | irq_set;
      end else begin
         irq_sts_q <= irq_sts_q | irq_set;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         irq_mask_q <= spft_pkg::IRQ_MASK_RESET;
      end else if (wr_imr) begin
         irq_mask_q <= wdata_i[3:0];
      end
   end

   // The mask resets open so the control enables alone decide by default.
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(irq_sts_q & irq_mask_q);
      end
   end

   // The status word is assembled apart so the read mux is a plain select.
   always_comb begin
      sts_word = 32'h0000_0000;
      sts_word[spft_pkg::STS_TX_CNT_LSB +: 4] = tx_cnt_q;
      sts_word[spft_pkg::STS_RX_CNT_LSB +: 4] = rx_cnt_q;
      sts_word[spft_pkg::STS_TX_FULL] = tx_full_q;
      sts_word[spft_pkg::STS_TX_EMPTY] = tx_empty_q;
      sts_word[spft_pkg::STS_RX_FULL] = rx_full_q;
      sts_word[spft_pkg::STS_RX_EMPTY] = rx_empty_q;
      sts_word[spft_pkg::STS_TIMEOUT] = timeout_q;
      sts_word[spft_pkg::STS_TX_LEVEL] = tx_level_q;
      sts_word[spft_pkg::STS_OVERRUN] = overrun_q;
      sts_word[spft_pkg::STS_RX_LEVEL] = rx_level_q;
   end

   // Read data stand for exactly the cycle after the read strobe.
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_q <= 32'h0000_0000;
      end else if (rd_i) begin
         case (addr_i)
            spft_pkg::OFS_FIFO_CTL: begin
               rdata_q <= ctrl_q;
            end
            spft_pkg::OFS_FIFO_STS: begin
               rdata_q <= sts_word;
            end
            spft_pkg::OFS_IRQ_STS: begin
               rdata_q <= {28'h000_0000, irq_sts_q};
            end
            spft_pkg::OFS_IRQ_MASK: begin
               rdata_q <= {28'h000_0000, irq_mask_q};
            end
            default: begin
               rdata_q <= 32'h0000_0000;
            end
         endcase
      end else begin
         rdata_q <= 32'h0000_0000;
      end
   end

   assign rdata_o = rdata_q;
   assign tx_count_o = tx_cnt_q;
   assign rx_count_o = rx_cnt_q;
   assign tx_full_o = tx_full_q;
   assign tx_empty_o = tx_empty_q;
   assign rx_full_o = rx_full_q;
   assign rx_empty_o = rx_empty_q;
   assign tx_level_flag_o = tx_level_q;
   assign rx_level_flag_o = rx_level_q;
   assign tx_flush_o = ctrl_q.tx_flush;
   assign rx_flush_o = ctrl_q.rx_flush;
   assign irq_o = irq_q;

endmodule : spft_fifo_ctrl

/* hw/spft_pkg.sv */
// Purpose: Shared constants and types for the serial FIFO threshold control.
// Assumes: 32-bit register words at byte offsets, FIFOs eight entries deep.
// Notes: The control word layout is carried as a packed struct.
package spft_pkg;
   localparam int ADDR_W = 8;
   localparam int CNT_W = 4;
   localparam logic [3:0] FIFO_DEPTH = 4'h8;

   localparam logic [7:0] OFS_FIFO_CTL = 8'h40;
   localparam logic [7:0] OFS_FIFO_STS = 8'h44;
   localparam logic [7:0] OFS_IRQ_STS = 8'h48;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h4c;

   localparam logic [31:0] CTRL_RESET = 32'h4400_0000;
   localparam logic [31:0] CTRL_WMASK = 32'h7720_004f;
   localparam logic [3:0] IRQ_MASK_RESET = 4'hf;

   // Status word bit positions.
   localparam int STS_TX_CNT_LSB = 28;
   localparam int STS_TX_FULL = 27;
   localparam int STS_TX_EMPTY = 26;
   localparam int STS_RX_FULL = 25;
   localparam int STS_RX_EMPTY = 24;
   localparam int STS_TIMEOUT = 20;
   localparam int STS_RX_CNT_LSB = 12;
   localparam int STS_TX_LEVEL = 4;
   localparam int STS_OVERRUN = 2;
   localparam int STS_RX_LEVEL = 0;

   // Interrupt status and mask bit positions.
   localparam int IRQ_RX_LEVEL = 0;
   localparam int IRQ_TX_LEVEL = 1;
   localparam int IRQ_OVERRUN = 2;
   localparam int IRQ_TIMEOUT = 3;

   // Idle time before the receive time-out, in serial clock periods and in
   // peripheral clock periods; one peripheral period is one ref clock cycle.
   localparam int TO_MASTER_SCLK = 64;
   localparam int TO_SLAVE_PCLK = 576;
   localparam int TO_CNT_W = 10;
   localparam logic [9:0] TO_MASTER_TICKS = 10'(TO_MASTER_SCLK);
   localparam logic [9:0] TO_SLAVE_CYCLES = 10'(TO_SLAVE_PCLK * 1);

   typedef struct packed {
      logic rsv31;
      logic [2:0] tx_thr;
      logic rsv27;
      logic [2:0] rx_thr;
      logic [1:0] rsv23;
      logic rx_idle_irq_enable;
      logic [13:0] rsv20;
      logic rx_overflow_irq_enable;
      logic [1:0] rsv5;
      logic tx_level_irq_enable;
      logic rx_level_irq_enable;
      logic tx_flush;
      logic rx_flush;
   } spft_ctrl_t;

   typedef enum logic [1:0] {
      SPFT_TO_IDLE = 2'b00,
      SPFT_TO_RUN = 2'b01,
      SPFT_TO_DONE = 2'b11
   } spft_to_state_t;
endpackage : spft_pkg

/* test/spft_fifo_ctrl_chk.sv */
// Purpose: Port-level assertions for the serial FIFO threshold control.
// Assumes: One clock domain; bound to every instance of the top module.
// Notes: Thresholds are mirrored from control writes, as no port shows them.
module spft_chk (
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic [7:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [31:0] rdata_o,
   input wire logic tx_push_i,
   input wire logic tx_pop_i,
   input wire logic rx_push_i,
   input wire logic rx_pop_i,
   input wire logic [3:0] tx_count_o,
   input wire logic [3:0] rx_count_o,
   input wire logic tx_full_o,
   input wire logic tx_empty_o,
   input wire logic rx_full_o,
   input wire logic rx_empty_o,
   input wire logic tx_level_flag_o,
   input wire logic rx_level_flag_o,
   input wire logic tx_flush_o,
   input wire logic rx_flush_o
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);
   logic [2:0] tx_thr_q;
   logic [2:0] rx_thr_q;
   logic ctl_wr;
   assign ctl_wr = wr_i && addr_i == spft_pkg::OFS_FIFO_CTL;
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tx_thr_q <= 3'h4;
         rx_thr_q <= 3'h4;
      end else if (ctl_wr) begin
         tx_thr_q <= wdata_i[30:28];
         rx_thr_q <= wdata_i[26:24];
      end
   end
   sequence tx_gone_s;
      tx_flush_o ##1 (tx_count_o == 4'h0 && tx_empty_o && !tx_full_o && !tx_flush_o);
   endsequence
   sequence rx_gone_s;
      rx_flush_o ##1 (rx_count_o == 4'h0 && rx_empty_o && !rx_full_o && !rx_flush_o);
   endsequence
   chk_tx_level: assert property ($stable(tx_thr_q) |->
      tx_level_flag_o == (tx_count_o <= {1'b0, tx_thr_q})) else $error("tx level wrong");
   chk_rx_level: assert property ($stable(rx_thr_q) |->
      rx_level_flag_o == (rx_count_o > {1'b0, rx_thr_q})) else $error("rx level wrong");
   chk_tx_flush: assert property (ctl_wr && wdata_i[1] |=> tx_gone_s)
      else $error("tx flush wrong");
   chk_rx_flush: assert property (ctl_wr && wdata_i[0] |=> rx_gone_s)
      else $error("rx flush wrong");
   chk_no_flush: assert property (!ctl_wr |=> !tx_flush_o && !rx_flush_o)
      else $error("stray flush");
   chk_tx_count: assert property (tx_push_i && !tx_pop_i && !tx_flush_o &&
      tx_count_o < 4'h8 |=> tx_count_o == $past(tx_count_o) + 4'h1) else $error("tx count");
   chk_rx_count: assert property (rx_pop_i && !rx_push_i && !rx_flush_o &&
      rx_count_o > 4'h0 |=> rx_count_o == $past(rx_count_o) - 4'h1) else $error("rx count");
   chk_rx_flags: assert property (rx_full_o == (rx_count_o == 4'h8) &&
      rx_empty_o == (rx_count_o == 4'h0)) else $error("rx flags");
   chk_tx_flags: assert property (tx_full_o == (tx_count_o == 4'h8) &&
      tx_empty_o == (tx_count_o == 4'h0)) else $error("tx flags");
   chk_read_idle: assert property (!rd_i |=> rdata_o == 32'h0)
      else $error("read data without read");
endmodule : spft_chk

bind spft_fifo_ctrl spft_chk spft_chk_i (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
   .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
   .tx_push_i(tx_push_i), .tx_pop_i(tx_pop_i), .rx_push_i(rx_push_i), .rx_pop_i(rx_pop_i),
   .tx_count_o(tx_count_o), .rx_count_o(rx_count_o), .tx_full_o(tx_full_o),
   .tx_empty_o(tx_empty_o), .rx_full_o(rx_full_o), .rx_empty_o(rx_empty_o),
   .tx_level_flag_o(tx_level_flag_o), .rx_level_flag_o(rx_level_flag_o),
   .tx_flush_o(tx_flush_o), .rx_flush_o(rx_flush_o));

/* test/tb.sv */
// Purpose: Self-checking bench for the serial FIFO threshold control.
// Assumes: 25 MHz clock; inputs change by non-blocking assignment at edges.
// Notes: Table rows cover thresholds; flush, irq and time-out follow by hand.
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {
      logic [2:0] tt;
      logic [2:0] rt;
      logic [3:0] n;
      logic tl;
      logic rl;
   } spft_row_t;
   logic ref_clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic [7:0] addr_i = 8'h0;
   logic [31:0] wdata_i = 32'h0;
   logic wr_i, rd_i, tx_push_i, tx_pop_i, rx_push_i, rx_pop_i, master_mode_i, sclk_tick_i;
   logic [31:0] rdata_o;
   logic [31:0] q;
   logic [3:0] tx_count_o, rx_count_o;
   logic tx_full_o, tx_empty_o, rx_full_o, rx_empty_o, tx_level_flag_o, rx_level_flag_o;
   logic tx_flush_o, rx_flush_o, irq_o;
   int errors = 0;
   int n_checks = 0;
   spft_row_t rows [7] = '{'{3'h4, 3'h4, 4'h4, 1'b1, 1'b0}, '{3'h4, 3'h4, 4'h5, 1'b0, 1'b1},
      '{3'h0, 3'h7, 4'h0, 1'b1, 1'b0}, '{3'h0, 3'h7, 4'h1, 1'b0, 1'b0},
      '{3'h7, 3'h0, 4'h8, 1'b0, 1'b1}, '{3'h7, 3'h0, 4'h1, 1'b1, 1'b1},
      '{3'h3, 3'h3, 4'h3, 1'b1, 1'b0}};
   logic [31:0] en [3] = '{32'h40, 32'h8, 32'h4};

   spft_fifo_ctrl spft_fifo_ctrl_i (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .tx_push_i(tx_push_i),
      .tx_pop_i(tx_pop_i), .rx_push_i(rx_push_i), .rx_pop_i(rx_pop_i),
      .master_mode_i(master_mode_i), .sclk_tick_i(sclk_tick_i), .tx_count_o(tx_count_o),
      .rx_count_o(rx_count_o), .tx_full_o(tx_full_o), .tx_empty_o(tx_empty_o),
      .rx_full_o(rx_full_o), .rx_empty_o(rx_empty_o), .tx_level_flag_o(tx_level_flag_o),
      .rx_level_flag_o(rx_level_flag_o), .tx_flush_o(tx_flush_o), .rx_flush_o(rx_flush_o),
      .irq_o(irq_o));

   always #20 ref_clk_i = ~ref_clk_i;
   // A tick every second cycle makes the serial clock half the ref clock.
   always @(posedge ref_clk_i) sclk_tick_i <= ~sclk_tick_i;

   task automatic close_out;
      if (errors == 0 && n_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : close_out

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge ref_clk_i);
      wr_i <= 1'b0;
   endtask : wr

   // Read data stand only in the cycle after the strobe, so sample there.
   task automatic rd(input logic [7:0] a);
      @(posedge ref_clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge ref_clk_i);
      rd_i <= 1'b0;
      #1 q = rdata_o;
   endtask : rd

   task automatic rc(input logic [7:0] a, input logic [31:0] e);
      rd(a);
      chk(q, e);
   endtask : rc

   // Bits of v: tx push, tx pop, rx push, rx pop; held for n cycles.
   task automatic pulse(input logic [3:0] v, input int n);
      repeat (n) begin
         @(posedge ref_clk_i);
         {tx_push_i, tx_pop_i, rx_push_i, rx_pop_i} <= v;
      end
      @(posedge ref_clk_i);
      {tx_push_i, tx_pop_i, rx_push_i, rx_pop_i} <= 4'h0;
   endtask : pulse

   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk_i);
      #1;
   endtask : cyc

   initial begin
      repeat (20000) @(posedge ref_clk_i);
      errors++;
      close_out();
   end

   initial begin
      {wr_i, rd_i, tx_push_i, tx_pop_i, rx_push_i, rx_pop_i, master_mode_i, sclk_tick_i} = '0;
      repeat (10) @(posedge ref_clk_i);
      rst_n_i <= 1'b1;
      rc(8'h40, 32'h4400_0000);
      rc(8'h44, 32'h0500_0010);
      rc(8'h4c, 32'hf);
      wr(8'h40, 32'hffff_ffff);
      rc(8'h40, 32'h7720_004c);
      wr(8'h50, 32'hffff_ffff);
      rc(8'h50, 32'h0);
      foreach (rows[i]) begin
         wr(8'h40, {1'b0, rows[i].tt, 1'b0, rows[i].rt, 24'h0});
         pulse(4'b1010, int'(rows[i].n));
         rd(8'h44);
         chk({q[31:28], q[15:12], q[4], q[0], tx_level_flag_o, rx_level_flag_o},
            {rows[i].n, rows[i].n, rows[i].tl, rows[i].rl, rows[i].tl, rows[i].rl});
         wr(8'h40, 32'h3);
         cyc(2);
      end
      pulse(4'b1010, 3);
      pulse(4'b0100, 1);
      wr(8'h40, 32'h0);
      cyc(2);
      chk({tx_count_o, rx_count_o}, 8'h23);
      wr(8'h40, 32'h2);
      cyc(2);
      chk({tx_count_o, tx_empty_o, rx_count_o, rx_empty_o}, 10'b0000_1_0011_0);
      wr(8'h40, 32'h1);
      cyc(2);
      chk({rx_count_o, rx_empty_o, rx_full_o}, 6'b0000_10);
      wr(8'h48, 32'hf);
      pulse(4'b0010, 9);
      rd(8'h44);
      chk({q[25], q[2], irq_o}, 3'b110);
      foreach (en[i]) begin
         wr(8'h40, en[i]);
         cyc(3);
         chk(irq_o, 1'b1);
         wr(8'h40, 32'h0);
         wr(8'h48, 32'hf);
         cyc(3);
         chk(irq_o, 1'b0);
      end
      wr(8'h40, 32'h8);
      wr(8'h4c, 32'h0);
      cyc(3);
      chk(irq_o, 1'b0);
      wr(8'h4c, 32'hf);
      cyc(3);
      chk(irq_o, 1'b1);
      wr(8'h44, 32'h4);
      rc(8'h44, 32'h0600_8011);
      wr(8'h40, 32'h0020_0001);
      wr(8'h48, 32'hf);
      for (int m = 0; m < 2; m++) begin
         @(posedge ref_clk_i);
         master_mode_i <= m[0];
         pulse(4'b0010, 1);
         cyc(m ? 100 : 540);
         rd(8'h44);
         chk(q[20], 1'b0);
         cyc(m ? 40 : 50);
         rd(8'h44);
         chk({q[20], irq_o}, 2'b11);
         pulse(4'b0001, 1);
         cyc(2);
         rc(8'h44, 32'h0500_0010);
         wr(8'h48, 32'hf);
      end
      close_out();
   end
endmodule : tb
